/* torque_cut_pkg.sv */
// Purpose: shared constants for the dual channel torque cut monitor
// Assumes: 10 MHz system clock
// Notes:   indication configuration codes and timing counts
package torque_cut_pkg;
  localparam int unsigned CLK_HZ          = 10_000_000;
  // pulse tolerance of each safety channel, in microseconds
  localparam int unsigned PULSE_TOL_US    = 1000;
  // filter must outlast the tolerated pulse: whole cycles per microsecond, plus one cycle
  localparam int unsigned PULSE_TOL_CYC   = (PULSE_TOL_US * (CLK_HZ / 1_000_000)) + 1;
  // allowed skew between the two channels, in milliseconds
  localparam int unsigned SKEW_MS         = 200;
  localparam int unsigned SKEW_CYC        = SKEW_MS * (CLK_HZ / 1000);
  // indication configuration codes (2 bits)
  localparam logic [1:0]  CFG_NONE        = 2'h0;
  localparam logic [1:0]  CFG_FAULT_RUN   = 2'h1;
  localparam logic [1:0]  CFG_WARN_ALL    = 2'h2;
  localparam logic [1:0]  CFG_FAULT_ALL   = 2'h3;
  // interrupt status bit positions
  localparam int unsigned EV_A_LOSS       = 0;
  localparam int unsigned EV_B_LOSS       = 1;
  localparam int unsigned EV_BOTH_LOST    = 2;
  localparam int unsigned EV_START_BLOCK  = 3;
  localparam int unsigned EV_W            = 4;
  // register addresses (word index on a plain port)
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h1;
  localparam logic [3:0]  ADDR_IRQ_STAT   = 4'h2;
  localparam logic [3:0]  ADDR_IRQ_MASK   = 4'h3;
  localparam logic [1:0]  CTRL_RST_CFG    = CFG_FAULT_ALL;
  localparam logic [EV_W-1:0] MASK_RST    = 4'h0;
endpackage

/* safety_input_sync.sv */
// Purpose: two stage synchroniser for one safety channel
// Assumes: input asynchronous to i_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/10ps
module safety_input_sync (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // channel
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= 1'b0;
      o_sync   <= 1'b0;
    end else begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule

/* pulse_filter.sv */
// Purpose: accept a level change only after it holds for a set time
// Assumes: input already synchronous
// Notes:   shorter pulses are ignored
`timescale 1ns/10ps
module pulse_filter #(
  parameter int unsigned HOLD_CYC = 10001
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst,
  // channel
  input  wire logic i_level,
  output logic      o_level
);
  localparam int unsigned CW = $clog2(HOLD_CYC + 1);
  logic [CW-1:0] cnt_reg;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= '0;
      o_level <= 1'b0;
    end else if (i_level == o_level) begin
      cnt_reg <= '0;
    end else if (cnt_reg == CW'(HOLD_CYC - 1)) begin
      cnt_reg <= '0;
      o_level <= i_level;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end
endmodule

/* torque_cut_monitor.sv */
// Purpose: dual channel torque cut monitor with restart interlock
// Assumes: 10 MHz clock, synchronous active high reset
// Notes:   registers on a plain strobe port, read data one cycle later
//
// Behaviour
// - ignore input pulses up to 1 ms
// - de-energized inputs withdraw output stage enable
// - indications selected by config, loss and run
// - config never affects the torque cut
// - stop running; block start until restored, reset
// - single channel loss longer than the skew window raises a fault
// - fresh start command needed after restore
// - cut is immediate, motor coasts, no ramp
// - separate fault per lost channel
//
// The plain strobed port and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module torque_cut_monitor
  import torque_cut_pkg::*;
#(
  parameter int unsigned FILT_CYC = PULSE_TOL_CYC,
  parameter int unsigned SKEW_LIM = SKEW_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // safety channels, high when energized
  input  wire logic        i_safety_input_a,
  input  wire logic        i_safety_input_b,
  // drive control
  input  wire logic        i_start_cmd,
  input  wire logic        i_stop_cmd,
  input  wire logic        i_fault_reset,
  // register port
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  // outputs
  output logic             o_drive_enable,
  output logic             o_running,
  output logic             o_channel_a_loss_fault,
  output logic             o_channel_b_loss_fault,
  output logic             o_torque_cut_fault,
  output logic             o_torque_cut_warning,
  output logic             o_irq
);
  typedef enum logic [2:0] {
    ST_STOPPED = 3'b001,
    ST_RUNNING = 3'b010,
    ST_WAIT    = 3'b100
  } run_state_e;

  run_state_e      state_reg;
  logic            sync_a;
  logic            sync_b;
  logic            filt_a;
  logic            filt_b;
  logic            filt_a_reg;
  logic            filt_b_reg;
  logic [1:0]      cfg_reg;
  logic [EV_W-1:0] irq_stat_reg;
  logic [EV_W-1:0] irq_mask_reg;
  logic [EV_W-1:0] ev;
  logic [$clog2(SKEW_LIM+1)-1:0] skew_reg;
  logic            both_ok;
  logic            one_lost;
  logic            all_lost;
  logic            fault_any;
  logic            a_fall;
  logic            b_fall;
  logic            loss_ev;
  logic            run_at_loss_reg;

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning
  safety_input_sync u_sync_a (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_safety_input_a),
    .o_sync  (sync_a)
  );
  safety_input_sync u_sync_b (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_async (i_safety_input_b),
    .o_sync  (sync_b)
  );
  pulse_filter #(.HOLD_CYC(FILT_CYC)) u_filt_a (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_level (sync_a),
    .o_level (filt_a)
  );
  pulse_filter #(.HOLD_CYC(FILT_CYC)) u_filt_b (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_level (sync_b),
    .o_level (filt_b)
  );

  assign both_ok   = filt_a & filt_b;
  assign all_lost  = ~filt_a & ~filt_b;
  assign one_lost  = filt_a ^ filt_b;
  assign a_fall    = filt_a_reg & ~filt_a;
  assign b_fall    = filt_b_reg & ~filt_b;
  assign loss_ev   = (a_fall | b_fall) & all_lost;
  assign fault_any = o_channel_a_loss_fault | o_channel_b_loss_fault | o_torque_cut_fault;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      filt_a_reg <= 1'b0;
      filt_b_reg <= 1'b0;
    end else begin
      filt_a_reg <= filt_a;
      filt_b_reg <= filt_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // discrepancy timer: one channel alone off longer than the skew window
  // is a channel loss; the source is expected to keep within it
  always_ff @(posedge i_clk) begin
    if (i_rst || !one_lost) begin
      skew_reg <= '0;
    end else if (skew_reg != ($clog2(SKEW_LIM+1))'(SKEW_LIM)) begin
      skew_reg <= skew_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // channel faults, independent of cfg; set wins over reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_channel_a_loss_fault <= 1'b0;
      o_channel_b_loss_fault <= 1'b0;
    end else begin
      if (one_lost && !filt_a && skew_reg == ($clog2(SKEW_LIM+1))'(SKEW_LIM)) begin
        o_channel_a_loss_fault <= 1'b1;
      end else if (i_fault_reset && both_ok) begin
        o_channel_a_loss_fault <= 1'b0;
      end
      if (one_lost && !filt_b && skew_reg == ($clog2(SKEW_LIM+1))'(SKEW_LIM)) begin
        o_channel_b_loss_fault <= 1'b1;
      end else if (i_fault_reset && both_ok) begin
        o_channel_b_loss_fault <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run state frozen at the first channel drop; the state itself has left
  // running by the time the second channel follows
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      run_at_loss_reg <= 1'b0;
    end else if (both_ok) begin
      run_at_loss_reg <= (state_reg == ST_RUNNING);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configurable indications: fault on loss of both channels, warning while either channel is lost
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_torque_cut_fault   <= 1'b0;
      o_torque_cut_warning <= 1'b0;
    end else begin
      if (loss_ev && (cfg_reg == CFG_FAULT_ALL ||
                      (cfg_reg == CFG_FAULT_RUN && run_at_loss_reg))) begin
        o_torque_cut_fault <= 1'b1;
      end else if (i_fault_reset && both_ok) begin
        o_torque_cut_fault <= 1'b0;
      end
      if (!both_ok && (cfg_reg == CFG_WARN_ALL ||
                       (cfg_reg == CFG_FAULT_RUN && !run_at_loss_reg))) begin
        o_torque_cut_warning <= 1'b1;
      end else begin
        o_torque_cut_warning <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run state and output stage enable
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_reg <= ST_STOPPED;
    end else begin
      case (state_reg)
        ST_STOPPED: begin
          if (!both_ok) begin
            state_reg <= ST_WAIT;
          end else if (i_start_cmd && !fault_any) begin
            state_reg <= ST_RUNNING;
          end
        end
        ST_RUNNING: begin
          if (!both_ok) begin
            state_reg <= ST_WAIT;
          end else if (i_stop_cmd) begin
            state_reg <= ST_STOPPED;
          end
        end
        ST_WAIT: begin
          // a start held over the restore is not a fresh one
          if (both_ok && !fault_any && !i_start_cmd) begin
            state_reg <= ST_STOPPED;
          end
        end
        default: state_reg <= ST_WAIT;
      endcase
    end
  end

  // enable drops one cycle after the filtered inputs fall; no ramp and
  // cfg plays no part
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_drive_enable <= 1'b0;
      o_running      <= 1'b0;
    end else begin
      o_drive_enable <= both_ok && (state_reg == ST_RUNNING ||
                        (state_reg == ST_STOPPED && i_start_cmd && !fault_any));
      o_running      <= both_ok && state_reg == ST_RUNNING;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status cleared by read, set wins
  always_comb begin
    ev                 = '0;
    ev[EV_A_LOSS]      = a_fall & filt_b;
    ev[EV_B_LOSS]      = b_fall & filt_a;
    ev[EV_BOTH_LOST]   = loss_ev;
    ev[EV_START_BLOCK] = i_start_cmd & (state_reg == ST_WAIT);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_stat_reg <= '0;
    end else if (i_rd && i_addr == ADDR_IRQ_STAT) begin
      irq_stat_reg <= ev;
    end else begin
      irq_stat_reg <= irq_stat_reg | ev;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cfg_reg      <= CTRL_RST_CFG;
      irq_mask_reg <= MASK_RST;
    end else if (i_wr) begin
      if (i_addr == ADDR_CTRL) begin
        cfg_reg <= i_wdata[1:0];
      end
      if (i_addr == ADDR_IRQ_MASK) begin
        irq_mask_reg <= i_wdata[EV_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_CTRL:     o_rdata <= {6'h00, cfg_reg};
        ADDR_STATUS:   o_rdata <= {filt_b, filt_a, state_reg, o_torque_cut_fault,
                                   o_channel_b_loss_fault, o_channel_a_loss_fault};
        ADDR_IRQ_STAT: o_rdata <= {4'h0, irq_stat_reg};
        ADDR_IRQ_MASK: o_rdata <= {4'h0, irq_mask_reg};
        default:       o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule

/* torque_cut_checker.sv */
// Purpose: port assertions for torque_cut_monitor
// Assumes: one clock, synchronous active high reset
// Notes:   low-time counters saturate
`timescale 1ns/10ps
module torque_cut_checker #(
  parameter int unsigned FILT_CYC = 4,
  parameter int unsigned SKEW_LIM = 20
) (
  // clock, reset and inputs
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic       i_safety_input_a,
  input wire logic       i_safety_input_b,
  input wire logic       i_start_cmd,
  input wire logic       i_fault_reset,
  input wire logic       i_rd,
  // outputs watched
  input wire logic [7:0] o_rdata,
  input wire logic       o_drive_enable,
  input wire logic       o_running,
  input wire logic       o_channel_a_loss_fault,
  input wire logic       o_channel_b_loss_fault,
  input wire logic       o_irq
);
  localparam int unsigned CUT = FILT_CYC + 5;
  localparam int unsigned FLT = FILT_CYC + SKEW_LIM + 8;
  logic [11:0] lo_a_reg, lo_b_reg, one_a_reg, one_b_reg;
  function automatic logic [11:0] up(input logic [11:0] c, input logic go);
    return go ? c + {11'h000, c != 12'hFFF} : 12'h000;
  endfunction
  always_ff @(posedge i_clk) begin
    lo_a_reg  <= i_rst ? 12'h000 : up(lo_a_reg, !i_safety_input_a);
    lo_b_reg  <= i_rst ? 12'h000 : up(lo_b_reg, !i_safety_input_b);
    one_a_reg <= i_rst ? 12'h000 : up(one_a_reg, !i_safety_input_a && i_safety_input_b);
    one_b_reg <= i_rst ? 12'h000 : up(one_b_reg, !i_safety_input_b && i_safety_input_a);
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_cut_a_loss: assert property (lo_a_reg >= CUT |-> !o_drive_enable)
    else $error("enable kept after channel a loss");
  a_cut_b_loss: assert property (lo_b_reg >= CUT |-> !o_drive_enable)
    else $error("enable kept after channel b loss");
  a_start_cause: assert property ($rose(o_drive_enable) |-> $past(i_start_cmd) &&
    !$past(o_channel_a_loss_fault) && !$past(o_channel_b_loss_fault))
    else $error("enable rose without start or with fault");
  a_run_order: assert property ($rose(o_running) |-> o_drive_enable && $past(o_drive_enable))
    else $error("running without enable");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read cycle");
  a_fault_hold: assert property ($fell(o_channel_a_loss_fault) ||
    $fell(o_channel_b_loss_fault) |-> $past(i_fault_reset) || $past(i_fault_reset, 2))
    else $error("fault cleared without reset");
  a_single_a_fault: assert property (one_a_reg >= FLT |-> o_channel_a_loss_fault)
    else $error("single loss of a not faulted");
  a_single_b_fault: assert property (one_b_reg >= FLT |-> o_channel_b_loss_fault)
    else $error("single loss of b not faulted");
  a_loss_id_a: assert property ($rose(o_channel_a_loss_fault) |-> lo_a_reg >= SKEW_LIM)
    else $error("a fault without a loss");
  a_loss_id_b: assert property ($rose(o_channel_b_loss_fault) |-> lo_b_reg >= SKEW_LIM)
    else $error("b fault without b loss");
  c_run: cover property ($rose(o_running));
  c_fault: cover property ($rose(o_channel_a_loss_fault));
  c_irq: cover property ($rose(o_irq));
endmodule

/* safety_source.sv */
// Purpose: two channel activation source for the safety inputs
// Assumes: channel b may trail channel a by a requested lag
// Notes:   high means contacts closed, lines always driven
`timescale 1ns/10ps
module safety_source #(
  parameter int unsigned SKEW_MAX = 20
) (
  input  wire logic       i_clk,
  input  wire logic       i_want_a,
  input  wire logic       i_want_b,
  input  wire logic [7:0] i_skew,
  output logic            o_a = 1'b0,
  output logic            o_b = 1'b0
);
  logic [7:0] lag_reg = 8'h00;
  always_ff @(posedge i_clk) o_a <= i_want_a;
  // lag is clipped below the allowed channel skew
  always_ff @(posedge i_clk) begin
    if (o_b == i_want_b) lag_reg <= 8'h00;
    else if (lag_reg >= i_skew || lag_reg >= 8'(SKEW_MAX - 1)) begin
      o_b     <= i_want_b;
      lag_reg <= 8'h00;
    end else lag_reg <= lag_reg + 8'h01;
  end
endmodule

/* testbench.sv */
// Purpose: self-checking bench for torque_cut_monitor
// Assumes: short filter and skew counts
// Notes:   expectations follow the channel and start sequence
`timescale 1ns/10ps
module testbench;
  import torque_cut_pkg::*;
  localparam int unsigned FC = 4;
  localparam int unsigned SK = 20;
  logic       i_clk = 1'b0, i_rst = 1'b1, want_a = 1'b0, want_b = 1'b0;
  logic       i_start_cmd = 1'b0, i_fault_reset = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, skew = 8'h00, rd, o_rdata;
  logic       ch_a, ch_b, o_drive_enable, o_running, fa, fb, o_irq, tf, tw;
  int         fails = 0, checked = 0, cyc = 0, seed = 94;
  safety_source #(.SKEW_MAX(SK)) src (.i_clk(i_clk), .i_want_a(want_a), .i_want_b(want_b),
    .i_skew(skew), .o_a(ch_a), .o_b(ch_b));
  torque_cut_monitor #(.FILT_CYC(FC), .SKEW_LIM(SK)) DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_safety_input_a(ch_a), .i_safety_input_b(ch_b), .i_start_cmd(i_start_cmd),
    .i_stop_cmd(1'b0), .i_fault_reset(i_fault_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_drive_enable(o_drive_enable),
    .o_running(o_running), .o_channel_a_loss_fault(fa), .o_channel_b_loss_fault(fb),
    .o_torque_cut_fault(tf), .o_torque_cut_warning(tw), .o_irq(o_irq));
  always #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rdr(input logic [3:0] a);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 rd = o_rdata;
  endtask
  task automatic wait_en(input logic v);
    repeat (60) begin
      @(posedge i_clk);
      #1;
      if (o_drive_enable === v) break;
    end
  endtask
  task automatic restore(input logic rst_f);
    @(posedge i_clk);
    want_a <= 1'b1;
    want_b <= 1'b1;
    repeat (FC + 8) @(posedge i_clk);
    i_fault_reset <= rst_f;
    repeat (3) @(posedge i_clk);
    i_fault_reset <= 1'b0;
  endtask
  task automatic start_up();
    @(posedge i_clk);
    i_start_cmd <= 1'b1;
    wait_en(1'b1);
    chk1("enable", 1'b1, o_drive_enable);
    @(posedge i_clk);
    i_start_cmd <= 1'b0;
    #1 chk1("running", 1'b1, o_running);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    rdr(ADDR_CTRL);
    chk8("ctrl", {6'h00, CTRL_RST_CFG}, rd);
    rdr(ADDR_IRQ_MASK);
    chk8("mask", {4'h0, MASK_RST}, rd);
    rdr(4'hF);
    chk8("unmapped", 8'h00, rd);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_CTRL, 8'(c));
      rdr(ADDR_CTRL);
      chk8("cfg", 8'(c), rd);
      restore(1'b1);
      start_up();
      want_a <= 1'b0;
      repeat (FC - 1) @(posedge i_clk);
      want_a <= 1'b1;
      repeat (FC + 8) @(posedge i_clk);
      #1 chk1("pulse", 1'b1, o_drive_enable);
      i_start_cmd <= 1'b1;
      skew   <= 8'($unsigned($random(seed)) % 10);
      want_a <= 1'b0;
      want_b <= 1'b0;
      wait_en(1'b0);
      chk1("cut", 1'b0, o_drive_enable);
      chk1("stop", 1'b0, o_running);
      chk1("fault a", 1'b0, fa);
      repeat (16) @(posedge i_clk);
      #1 chk1("tc fault", 1'(c == 3 || c == 1), tf);
      chk1("tc warn", 1'(c == 2), tw);
      restore(1'b1);
      repeat (20) @(posedge i_clk);
      #1 chk1("no restart", 1'b0, o_drive_enable);
      i_start_cmd <= 1'b0;
    end
    for (int c = 0; c < 2; c++) begin
      wr(ADDR_IRQ_MASK, c == 0 ? 8'h0F : 8'h00);
      restore(1'b1);
      start_up();
      if (c == 0) want_a <= 1'b0;
      else want_b <= 1'b0;
      repeat (FC + SK + 14) @(posedge i_clk);
      #1 chk1("fault a", 1'(c == 0), fa);
      chk1("fault b", 1'(c == 1), fb);
      chk1("cut", 1'b0, o_drive_enable);
      chk1("irq", 1'(c == 0), o_irq);
      rdr(ADDR_IRQ_STAT);
      chk8("irq stat", 8'(1 << c), rd & 8'h03);
      repeat (2) @(posedge i_clk);
      #1 chk1("irq clear", 1'b0, o_irq);
      restore(1'b0);
      i_start_cmd <= 1'b1;
      repeat (10) @(posedge i_clk);
      #1 chk1("blocked", 1'b0, o_drive_enable);
      i_start_cmd <= 1'b0;
      restore(1'b1);
      #1 chk1("fault clr", 1'b0, fa | fb);
      start_up();
    end
    end_sim();
  end
endmodule
bind torque_cut_monitor torque_cut_checker #(.FILT_CYC(FILT_CYC), .SKEW_LIM(SKEW_LIM)) chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_safety_input_a(i_safety_input_a),
  .i_safety_input_b(i_safety_input_b), .i_start_cmd(i_start_cmd),
  .i_fault_reset(i_fault_reset), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_drive_enable(o_drive_enable), .o_running(o_running),
  .o_channel_a_loss_fault(o_channel_a_loss_fault),
  .o_channel_b_loss_fault(o_channel_b_loss_fault), .o_irq(o_irq));
